// ==== ftc_regs.svh ====
// register offsets, field positions and reset values of the free running timer counter
`ifndef FTC_REGS_SVH
`define FTC_REGS_SVH

`define FTC_ADDR_W          6
`define FTC_OFF_CNT_HI      6'h00
`define FTC_OFF_CNT_LO      6'h04
`define FTC_OFF_ALT_HI      6'h08
`define FTC_OFF_ALT_LO      6'h0c
`define FTC_OFF_STATUS      6'h10
`define FTC_OFF_CTRL_ONE    6'h14
`define FTC_OFF_CTRL_TWO    6'h18

`define FTC_CNT_RESET       16'hfffc
`define FTC_CNT_MAX         16'hffff

`define FTC_STAT_OVF_BIT    0
`define FTC_C1_OVF_IE_BIT   0
`define FTC_C2_CC_LSB       0
`define FTC_C2_CC_MSB       1
`define FTC_C2_EDGE_BIT     2

`define FTC_CC_DIV4         2'h0
`define FTC_CC_DIV2         2'h1
`define FTC_CC_DIV8         2'h2
`define FTC_CC_EXT          2'h3

`define FTC_DIV2_MASK       3'h1
`define FTC_DIV4_MASK       3'h3
`define FTC_DIV8_MASK       3'h7

`define FTC_RESP_OKAY       2'h0
`define FTC_RESP_SLVERR     2'h2

`endif

// ==== ftc_pkg.sv ====
// shared types of the free running timer counter
package ftc_pkg;
    typedef logic [7:0]  ftc_byte_t;
    typedef logic [15:0] ftc_count_t;
    typedef logic [1:0]  ftc_clk_sel_t;
    typedef logic [2:0]  ftc_div_t;
endpackage : ftc_pkg

// ==== ftc_ext_sync.sv ====
// two-stage synchroniser and selectable edge detector for the external count clock
`timescale 1ns/1ns
`default_nettype none
module ftc_ext_sync
    import ftc_pkg::*;
(
    input  wire logic CLK,       // cpu clock
    input  wire logic RST_N,     // async reset, active low
    input  wire logic PIN,       // raw external count clock
    input  wire logic EDGE_SEL,  // 1 rising edge counts, 0 falling edge counts
    output logic      TICK       // one-cycle pulse per selected edge
);
    logic meta_q;
    logic sync_q;
    logic prev_q;

    // meta_q is read only by sync_q
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
            prev_q <= 1'b1;
        end else begin
            meta_q <= PIN;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // edge seen on the synchronised level only
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            TICK <= 1'b0;
        end else begin
            TICK <= EDGE_SEL ? (sync_q & ~prev_q) : (~sync_q & prev_q);
        end
    end
endmodule : ftc_ext_sync
`default_nettype wire

// ==== ftc_timer.sv ====
// free running 16-bit timer counter core with an AXI4-Lite register slave
`timescale 1ns/1ns
`default_nettype none
`include "ftc_regs.svh"
module ftc_timer
    import ftc_pkg::*;
#(
    parameter bit EXT_PIN_BONDED = 1'b1  // external count clock pin present
) (
    input  wire logic        CLK,            // cpu clock, 10 MHz
    input  wire logic        RST_N,          // async reset, active low
    input  wire logic        EXT_CLK_PIN,    // external count clock
    input  wire logic        CPU_IRQ_MASK,   // cpu interrupt mask bit, 1 masks
    input  wire logic        HALT_MODE,      // cpu in halt, counter frozen
    input  wire logic        WAIT_MODE,      // cpu in wait, no effect
    input  wire logic [31:0] S_AXI_AWADDR,   // write address
    input  wire logic        S_AXI_AWVALID,  // write address valid
    output logic             S_AXI_AWREADY,  // write address ready
    input  wire logic [31:0] S_AXI_WDATA,    // write data
    input  wire logic [3:0]  S_AXI_WSTRB,    // write byte enables
    input  wire logic        S_AXI_WVALID,   // write data valid
    output logic             S_AXI_WREADY,   // write data ready
    output logic [1:0]       S_AXI_BRESP,    // write response
    output logic             S_AXI_BVALID,   // write response valid
    input  wire logic        S_AXI_BREADY,   // write response ready
    input  wire logic [31:0] S_AXI_ARADDR,   // read address
    input  wire logic        S_AXI_ARVALID,  // read address valid
    output logic             S_AXI_ARREADY,  // read address ready
    output logic [31:0]      S_AXI_RDATA,    // read data
    output logic [1:0]       S_AXI_RRESP,    // read response
    output logic             S_AXI_RVALID,   // read data valid
    input  wire logic        S_AXI_RREADY,   // read data ready
    output logic             OVF_IRQ         // overflow interrupt request, active high
);

    // word decode shared by both channels
    function automatic logic [2:0] ftc_decode(input logic [31:0] addr, output logic hit);
        logic [`FTC_ADDR_W-1:0] a;
        a   = addr[`FTC_ADDR_W-1:0];
        hit = (addr[31:`FTC_ADDR_W] == '0);
        case (a)
            `FTC_OFF_CNT_HI:   ftc_decode = 3'h0;
            `FTC_OFF_CNT_LO:   ftc_decode = 3'h1;
            `FTC_OFF_ALT_HI:   ftc_decode = 3'h2;
            `FTC_OFF_ALT_LO:   ftc_decode = 3'h3;
            `FTC_OFF_STATUS:   ftc_decode = 3'h4;
            `FTC_OFF_CTRL_ONE: ftc_decode = 3'h5;
            `FTC_OFF_CTRL_TWO: ftc_decode = 3'h6;
            default: begin
                ftc_decode = 3'h7;
                hit        = 1'b0;
            end
        endcase
    endfunction : ftc_decode

    localparam logic [2:0] SEL_CNT_HI = 3'h0;
    localparam logic [2:0] SEL_CNT_LO = 3'h1;
    localparam logic [2:0] SEL_ALT_HI = 3'h2;
    localparam logic [2:0] SEL_ALT_LO = 3'h3;
    localparam logic [2:0] SEL_STATUS = 3'h4;
    localparam logic [2:0] SEL_CTRL1  = 3'h5;
    localparam logic [2:0] SEL_CTRL2  = 3'h6;

    // state
    ftc_count_t   cnt_q;
    ftc_div_t     div_q;
    ftc_byte_t    lo_buf_q;
    logic         lo_buf_vld_q;
    logic         ovf_flag_q;
    logic         ovf_armed_q;
    logic         ovf_ie_q;
    ftc_clk_sel_t clk_sel_q;
    logic         ext_edge_q;

    // bus state
    logic         aw_full_q;
    logic         w_full_q;
    logic [31:0]  aw_addr_q;
    logic [31:0]  w_data_q;
    logic [3:0]   w_strb_q;

    // derived
    logic         ext_pin;
    logic         ext_tick;
    logic         pre_tick;
    logic         cnt_tick;
    logic         do_wr;
    logic         wr_hit;
    logic [2:0]   wr_sel;
    logic         wr_lo_lane;
    logic         rd_take;
    logic         rd_hit;
    logic [2:0]   rd_sel;
    logic         rd_hi;
    logic         rd_lo_main;
    logic         cnt_reload;
    logic         ovf_set;
    logic         ovf_clr;
    logic         aw_full_d;
    logic         w_full_d;
    logic         rvalid_d;
    logic [7:0]   rd_byte;

    assign ext_pin = EXT_PIN_BONDED ? EXT_CLK_PIN : 1'b1;

    ftc_ext_sync u_ext_sync (
        .CLK      (CLK),
        .RST_N    (RST_N),
        .PIN      (ext_pin),
        .EDGE_SEL (ext_edge_q),
        .TICK     (ext_tick)
    );

    // prescaler runs from reset so two instances stay in step
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            div_q <= '0;
        end else if (!HALT_MODE) begin
            div_q <= div_q + 3'h1;
        end
    end

    always_comb begin
        case (clk_sel_q)
            `FTC_CC_DIV2: pre_tick = ((div_q & `FTC_DIV2_MASK) == `FTC_DIV2_MASK);
            `FTC_CC_DIV4: pre_tick = ((div_q & `FTC_DIV4_MASK) == `FTC_DIV4_MASK);
            `FTC_CC_DIV8: pre_tick = ((div_q & `FTC_DIV8_MASK) == `FTC_DIV8_MASK);
            // without the pin the external setting never counts
            `FTC_CC_EXT:  pre_tick = EXT_PIN_BONDED & ext_tick;
            default:      pre_tick = 1'b0;
        endcase
    end

    // wait does not gate counting, halt does
    assign cnt_tick = pre_tick & ~HALT_MODE & (WAIT_MODE | ~WAIT_MODE);

    // write channel: address and data taken in either order
    assign do_wr     = aw_full_q & w_full_q & ~S_AXI_BVALID;
    assign aw_full_d = (aw_full_q & ~do_wr) | (S_AXI_AWVALID & S_AXI_AWREADY);
    assign w_full_d  = (w_full_q & ~do_wr) | (S_AXI_WVALID & S_AXI_WREADY);

    always_comb begin
        wr_hit = 1'b0;
        wr_sel = ftc_decode(aw_addr_q, wr_hit);
    end

    assign wr_lo_lane = do_wr & wr_hit & w_strb_q[0];

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            aw_full_q     <= 1'b0;
            w_full_q      <= 1'b0;
            aw_addr_q     <= '0;
            w_data_q      <= '0;
            w_strb_q      <= '0;
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY  <= 1'b0;
        end else begin
            aw_full_q     <= aw_full_d;
            w_full_q      <= w_full_d;
            S_AXI_AWREADY <= ~aw_full_d;
            S_AXI_WREADY  <= ~w_full_d;
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_addr_q <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_data_q <= S_AXI_WDATA;
                w_strb_q <= S_AXI_WSTRB;
            end
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP  <= `FTC_RESP_OKAY;
        end else if (do_wr) begin
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP  <= wr_hit ? `FTC_RESP_OKAY : `FTC_RESP_SLVERR;
        end else if (S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
        end
    end

    // software control bits
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ovf_ie_q   <= 1'b0;
            clk_sel_q  <= `FTC_CC_DIV4;
            ext_edge_q <= 1'b0;
        end else if (wr_lo_lane) begin
            if (wr_sel == SEL_CTRL1) begin
                ovf_ie_q <= w_data_q[`FTC_C1_OVF_IE_BIT];
            end
            if (wr_sel == SEL_CTRL2) begin
                clk_sel_q  <= w_data_q[`FTC_C2_CC_MSB:`FTC_C2_CC_LSB];
                ext_edge_q <= w_data_q[`FTC_C2_EDGE_BIT];
            end
        end
    end

    // read channel: one read in flight, answered the cycle after it is taken
    assign rd_take  = S_AXI_ARVALID & S_AXI_ARREADY;
    assign rvalid_d = rd_take | (S_AXI_RVALID & ~S_AXI_RREADY);

    always_comb begin
        rd_hit = 1'b0;
        rd_sel = ftc_decode(S_AXI_ARADDR, rd_hit);
    end

    assign rd_hi      = rd_take & rd_hit & ((rd_sel == SEL_CNT_HI) | (rd_sel == SEL_ALT_HI));
    assign rd_lo_main = rd_take & rd_hit & (rd_sel == SEL_CNT_LO);

    always_comb begin
        case (rd_sel)
            SEL_CNT_HI: rd_byte = cnt_q[15:8];
            SEL_ALT_HI: rd_byte = cnt_q[15:8];
            SEL_CNT_LO: rd_byte = lo_buf_vld_q ? lo_buf_q : cnt_q[7:0];
            SEL_ALT_LO: rd_byte = lo_buf_vld_q ? lo_buf_q : cnt_q[7:0];
            SEL_STATUS: rd_byte = 8'(ovf_flag_q) << `FTC_STAT_OVF_BIT;
            SEL_CTRL1:  rd_byte = 8'(ovf_ie_q) << `FTC_C1_OVF_IE_BIT;
            SEL_CTRL2:  rd_byte = {5'h00, ext_edge_q, clk_sel_q};
            default:    rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            S_AXI_RVALID  <= 1'b0;
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RDATA   <= '0;
            S_AXI_RRESP   <= `FTC_RESP_OKAY;
        end else begin
            S_AXI_RVALID  <= rvalid_d;
            S_AXI_ARREADY <= ~rvalid_d;
            if (rd_take) begin
                S_AXI_RDATA <= rd_hit ? {24'h000000, rd_byte} : 32'h00000000;
                S_AXI_RRESP <= rd_hit ? `FTC_RESP_OKAY : `FTC_RESP_SLVERR;
            end
        end
    end

    // low byte buffer; one buffer serves both views, as one sequence is run at a time
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            lo_buf_q     <= '0;
            lo_buf_vld_q <= 1'b0;
        end else if (rd_hi && !lo_buf_vld_q) begin
            lo_buf_q     <= cnt_q[7:0];
            lo_buf_vld_q <= 1'b1;
        end else if (rd_take && rd_hit && (rd_sel == SEL_CNT_LO || rd_sel == SEL_ALT_LO)) begin
            lo_buf_vld_q <= 1'b0;
        end
    end

    // counter; a reload wins over a tick in the same cycle
    assign cnt_reload = wr_lo_lane & ((wr_sel == SEL_CNT_LO) | (wr_sel == SEL_ALT_LO));

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            cnt_q <= `FTC_CNT_RESET;
        end else if (cnt_reload) begin
            cnt_q <= `FTC_CNT_RESET;
        end else if (cnt_tick) begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end

    // overflow flag with two-step clear; a rollover in the clearing cycle wins
    assign ovf_set = cnt_tick & ~cnt_reload & (cnt_q == `FTC_CNT_MAX);
    assign ovf_clr = ovf_armed_q &
                     (rd_lo_main | (wr_lo_lane & (wr_sel == SEL_CNT_LO)));

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ovf_flag_q <= 1'b0;
        end else if (ovf_set) begin
            ovf_flag_q <= 1'b1;
        end else if (ovf_clr) begin
            ovf_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ovf_armed_q <= 1'b0;
        end else if (rd_take && rd_hit && rd_sel == SEL_STATUS && ovf_flag_q) begin
            ovf_armed_q <= 1'b1;
        end else if (ovf_clr || !ovf_flag_q) begin
            ovf_armed_q <= 1'b0;
        end
    end

    // request is held low while masked or disabled; ovf_flag_q stays set and raises it again once unmasked and enabled
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            OVF_IRQ <= 1'b0;
        end else begin
            OVF_IRQ <= ovf_flag_q & ovf_ie_q & ~CPU_IRQ_MASK;
        end
    end

endmodule : ftc_timer
`default_nettype wire

// ==== ftc_timer_assertions.sv ====
// concurrent checks on the ports of the timer counter core
`timescale 1ns/1ns
`default_nettype none
`include "ftc_regs.svh"
module ftc_timer_chk (
    input wire logic        CLK,            // cpu clock
    input wire logic        RST_N,          // async reset, active low
    input wire logic        CPU_IRQ_MASK,   // cpu interrupt mask
    input wire logic        S_AXI_AWVALID,  // write address valid
    input wire logic        S_AXI_AWREADY,  // write address ready
    input wire logic        S_AXI_WVALID,   // write data valid
    input wire logic        S_AXI_WREADY,   // write data ready
    input wire logic [1:0]  S_AXI_BRESP,    // write response
    input wire logic        S_AXI_BVALID,   // write response valid
    input wire logic        S_AXI_BREADY,   // write response ready
    input wire logic [31:0] S_AXI_ARADDR,   // read address
    input wire logic        S_AXI_ARVALID,  // read address valid
    input wire logic        S_AXI_ARREADY,  // read address ready
    input wire logic [31:0] S_AXI_RDATA,    // read data
    input wire logic [1:0]  S_AXI_RRESP,    // read response
    input wire logic        S_AXI_RVALID,   // read data valid
    input wire logic        S_AXI_RREADY,   // read data ready
    input wire logic        OVF_IRQ         // overflow request
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);

    chk_rvalid_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
        else $error("read answer dropped or changed before rready");
    chk_bvalid_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
        else $error("write answer dropped or changed before bready");
    chk_read_lat: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
        else $error("read answer not one cycle after address");
    chk_write_resp: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
        |-> ##[1:3] S_AXI_BVALID)
        else $error("write answer missing");
    chk_upper_zero: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h0)
        else $error("upper read bits not zero");
    chk_unmapped_err: assert property (S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR[31:6] != 26'h0
        |=> S_AXI_RRESP == `FTC_RESP_SLVERR && S_AXI_RDATA == 32'h0)
        else $error("out of range read not refused");
    chk_ar_blocked: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
        else $error("address taken while read answer pending");
    chk_irq_mask: assert property (OVF_IRQ |-> !$past(CPU_IRQ_MASK))
        else $error("request raised while cpu mask set");
    // with no bus access the flag cannot be cleared, so an unmasked request must stay
    chk_irq_held: assert property ((OVF_IRQ && !CPU_IRQ_MASK && !S_AXI_ARVALID && !S_AXI_AWVALID
        && !S_AXI_WVALID) [*4] |=> OVF_IRQ)
        else $error("request vanished without an access");
endmodule : ftc_timer_chk

bind ftc_timer ftc_timer_chk i_chk (.CLK, .RST_N, .CPU_IRQ_MASK, .S_AXI_AWVALID, .S_AXI_AWREADY,
    .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR,
    .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY,
    .OVF_IRQ);
`default_nettype wire

// ==== ftc_ext_clk_model.sv ====
// external count clock source: bursts of pin toggles, still between bursts
`timescale 1ns/1ns
`default_nettype none
module ftc_ext_clk_model (
    input  wire logic       CLK,      // cpu clock
    input  wire logic       RST_N,    // async reset, active low
    input  wire logic       GO,       // start a burst
    input  wire logic [3:0] TOGGLES,  // pin changes in the burst
    output logic            PIN,      // external count clock
    output logic            BUSY      // burst in progress
);
    logic [3:0] left_q;
    logic [1:0] gap_q;

    // a change every four cycles keeps like edges eight cycles apart
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            left_q <= 4'h0;
            gap_q  <= 2'h0;
            // idles high like an unbonded input, so no false edge follows reset
            PIN    <= 1'b1;
        end else if (GO && left_q == 4'h0) begin
            left_q <= TOGGLES;
            gap_q  <= 2'h0;
        end else if (left_q != 4'h0) begin
            gap_q <= gap_q + 2'h1;
            if (gap_q == 2'h3) begin
                PIN    <= ~PIN;
                left_q <= left_q - 4'h1;
            end
        end
    end

    assign BUSY = left_q != 4'h0;
endmodule : ftc_ext_clk_model
`default_nettype wire

// ==== ftc_timer_tb_top.sv ====
// self-checking bench for the free running timer counter core
`timescale 1ns/1ns
`default_nettype none
`include "ftc_regs.svh"
module ftc_timer_tb_top
    import ftc_pkg::*;
;
    logic         clk;
    logic         rst_n    = 1'b0;
    logic         irq_mask = 1'b0;
    logic         halt     = 1'b1;
    logic         waitm    = 1'b0;
    logic         go       = 1'b0;
    logic [3:0]   toggles  = 4'h0;
    logic [31:0]  awaddr   = 32'h0;
    logic [31:0]  wdata    = 32'h0;
    logic [31:0]  araddr   = 32'h0;
    logic         awvalid  = 1'b0;
    logic         wvalid   = 1'b0;
    logic         bready   = 1'b0;
    logic         arvalid  = 1'b0;
    logic         rready   = 1'b0;
    logic         ext_pin, ext_busy, awready, wready, bvalid, arready, rvalid, ovf_irq;
    logic [1:0]   bresp, rresp, resp;
    logic [31:0]  rdata, v;
    int           mismatches, num_checks;
    ftc_clk_sel_t sels [3] = '{`FTC_CC_DIV4, `FTC_CC_DIV8, `FTC_CC_DIV2};
    int           divs [3] = '{4, 8, 2};
    logic [31:0]  bad  [2] = '{32'h1c, 32'h40};

    ftc_timer i_dut (
        .CLK(clk), .RST_N(rst_n), .EXT_CLK_PIN(ext_pin), .CPU_IRQ_MASK(irq_mask),
        .HALT_MODE(halt), .WAIT_MODE(waitm), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf),
        .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .OVF_IRQ(ovf_irq));

    ftc_ext_clk_model i_ext (.CLK(clk), .RST_N(rst_n), .GO(go), .TOGGLES(toggles),
        .PIN(ext_pin), .BUSY(ext_busy));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic test_done();
        if (mismatches == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : test_done

    // address and data are offered together; each is dropped once its own ready is seen
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done  = 1'b0;
        @(posedge clk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge clk);
            if (awready === 1'b1 && !aw_done) begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (wready === 1'b1 && !w_done) begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end while (!(aw_done && w_done));
        do @(posedge clk); while (bvalid !== 1'b1);
        resp = bresp;
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [31:0] a, output logic [31:0] d);
        @(posedge clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk); while (rvalid !== 1'b1);
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask : rd

    task automatic rd16(input logic [31:0] a, output logic [31:0] d);
        logic [31:0] h;
        logic [31:0] l;
        rd(a, h);
        rd(a + 32'h4, l);
        d = {16'h0, h[7:0], l[7:0]};
    endtask : rd16

    // counter and prescaler only move while halt is low, so n cycles give exact counts
    task automatic run(input int n);
        halt <= 1'b0;
        repeat (n) @(posedge clk);
        halt <= 1'b1;
    endtask : run

    task automatic ext_burst(input logic [31:0] ctl, input logic [3:0] n, input logic [15:0] e);
        wr(`FTC_OFF_CTRL_TWO, ctl);
        wr(`FTC_OFF_CNT_LO, 32'h0);
        toggles <= n;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        do @(posedge clk); while (ext_busy);
        repeat (6) @(posedge clk);
        rd16(`FTC_OFF_CNT_HI, v);
        check(v, {16'h0, e});
    endtask : ext_burst

    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        test_done();
    end

    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        rd16(`FTC_OFF_CNT_HI, v);
        check(v, 32'hfffc);
        rd16(`FTC_OFF_ALT_HI, v);
        check(v, 32'hfffc);
        rd(`FTC_OFF_STATUS, v);
        check(v, 32'h0);
        for (int i = 0; i < 3; i++) begin
            wr(`FTC_OFF_CTRL_TWO, {30'h0, sels[i]});
            wr(`FTC_OFF_CNT_LO, 32'h0);
            waitm <= (i == 1);
            run(8);
            rd16(`FTC_OFF_CNT_HI, v);
            check(v, {16'h0, 16'(16'hfffc + 8 / divs[i])});
            rd(`FTC_OFF_STATUS, v);
            check(v, {31'h0, i == 2});
        end
        wr(`FTC_OFF_CTRL_ONE, 32'h1);
        repeat (3) @(posedge clk);
        check(ovf_irq, 32'h1);
        irq_mask <= 1'b1;
        repeat (3) @(posedge clk);
        check(ovf_irq, 32'h0);
        irq_mask <= 1'b0;
        rd(`FTC_OFF_ALT_LO, v);
        rd(`FTC_OFF_STATUS, v);
        check(v, 32'h1);
        rd(`FTC_OFF_CNT_LO, v);
        rd(`FTC_OFF_STATUS, v);
        check(v, 32'h0);
        check(ovf_irq, 32'h0);
        wr(`FTC_OFF_CNT_LO, 32'h0);
        rd(`FTC_OFF_CNT_HI, v);
        check(v, 32'hff);
        run(10);
        rd(`FTC_OFF_ALT_HI, v);
        check(v, 32'h0);
        rd(`FTC_OFF_CNT_LO, v);
        check(v, 32'hfc);
        rd(`FTC_OFF_CNT_LO, v);
        check(v, 32'h01);
        for (int i = 0; i < 2; i++) begin
            rd(bad[i], v);
            check(v, 32'h0);
            check(resp, `FTC_RESP_SLVERR);
            wr(bad[i], 32'h1);
            check(resp, `FTC_RESP_SLVERR);
        end
        halt <= 1'b0;
        ext_burst(32'h7, 4'h5, 16'hfffe);
        ext_burst(32'h3, 4'h3, 16'hfffd);
        halt  <= 1'b1;
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        rd16(`FTC_OFF_CNT_HI, v);
        check(v, 32'hfffc);
        test_done();
    end
endmodule : ftc_timer_tb_top
`default_nettype wire
